// file: cfl_macro_model.sv
// behavioural recovery macro: reference, divided oscillator, error pulses
// assumes the bench sets osc_per in ns and calls err_pulses
`timescale 1ns/1ps
module cfl_macro_model (
  input  wire logic [11:0] osc_per,
  output logic             ref_clk,
  output logic             osc_clk,
  output logic             bit_err
);
  // reference period 400 ns, 40 clocks
  initial begin
    ref_clk = 1'b0;
    forever #200 ref_clk = ~ref_clk;
  end
  // test-select pair held in static test mode
  logic test_sel_true;
  logic test_sel_comp;
  initial begin
    test_sel_true = 1'b1;
    test_sel_comp = 1'b0;
  end
  // period is osc_per + 2 (osc_per + 1 when odd) so a zero never stalls time
  // wait one step so the bench has set osc_per before the first delay
  initial begin
    osc_clk = 1'b0;
    #1;
    forever #(osc_per / 2 + 1) osc_clk = ~osc_clk;
  end
  initial bit_err = 1'b0;
  // pulses last 3 clocks so the synchroniser sees each one
  // error pulses only come out while test mode is selected
  task automatic err_pulses(input int n, input int gap);
    repeat (n) begin
      bit_err = test_sel_true && !test_sel_comp;
      #30;
      bit_err = 1'b0;
      #(gap);
    end
  endtask
endmodule

// file: cfl_pulse_former.sv
// package of constants for the recovery support logic, plus the pulse former
// assumes one clock domain; requests arrive as one-cycle pulses
package cfl_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned FD_PULSE_NS    = 80;
  localparam int unsigned FD_PULSE_CYC   =
    (FD_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REF_DIV_N      = 16;
  localparam int unsigned VCO_DIV_X      = 4;
  localparam int unsigned FD_CNT_W       = 16;
  localparam int unsigned FD_WIN_LO      = 100;
  localparam int unsigned FD_WIN_HI      = 120;
  localparam int unsigned LOS_INTERVAL   = 65536;
  localparam int unsigned LOS_SET_THR    = 128;
  localparam int unsigned LOS_CLR_THR    = 65;
  localparam int unsigned ERR_CNT_W      = 17;
  localparam int unsigned DIV_CNT_W      = 17;
  localparam int unsigned PULSE_CNT_W    = 8;
endpackage

`timescale 1ns/1ps
module cfl_pulse_former #(
  parameter int unsigned WIDTH = cfl_pkg::FD_PULSE_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sync_rst,
  input  wire logic up_req,
  input  wire logic dn_req,
  output logic      up_pulse,
  output logic      dn_pulse
);
  import cfl_pkg::*;

  logic [PULSE_CNT_W-1:0] cnt_reg;
  logic [PULSE_CNT_W-1:0] cnt_next;
  logic                   up_reg;
  logic                   up_next;
  logic                   dn_reg;
  logic                   dn_next;

  // one fixed-width pulse per request; a request during a pulse restarts it
  always_comb begin
    cnt_next = cnt_reg;
    up_next  = up_reg;
    dn_next  = dn_reg;
    if (sync_rst) begin
      cnt_next = '0;
      up_next  = 1'b0;
      dn_next  = 1'b0;
    end else if (up_req || dn_req) begin
      cnt_next = PULSE_CNT_W'(WIDTH);
      up_next  = up_req;
      dn_next  = dn_req && !up_req;
    end else if (cnt_reg > PULSE_CNT_W'(1)) begin
      cnt_next = cnt_reg - PULSE_CNT_W'(1);
    end else begin
      cnt_next = '0;
      up_next  = 1'b0;
      dn_next  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      up_reg  <= 1'b0;
      dn_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      up_reg  <= up_next;
      dn_reg  <= dn_next;
    end
  end

  assign up_pulse = up_reg;
  assign dn_pulse = dn_reg;
endmodule

// file: cfl_recovery_support.sv
// core-side logic beside a clock recovery macro: frequency window detector,
// phase signal gating, carrier-absent detection and 1:2 data split
// assumes reference clock, divided oscillator clock and error pulses are
// slow against CLK and come from outside its domain
`timescale 1ns/1ps
module cfl_recovery_support #(
  parameter int unsigned N_DIV     = cfl_pkg::REF_DIV_N,
  parameter int unsigned X_DIV     = cfl_pkg::VCO_DIV_X,
  parameter int unsigned WIN_LO    = cfl_pkg::FD_WIN_LO,
  parameter int unsigned WIN_HI    = cfl_pkg::FD_WIN_HI,
  parameter int unsigned LOS_INT   = cfl_pkg::LOS_INTERVAL,
  parameter int unsigned SET_THR   = cfl_pkg::LOS_SET_THR,
  parameter int unsigned CLR_THR   = cfl_pkg::LOS_CLR_THR
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic SYNC_RST,
  input  wire logic REF_CLK,
  input  wire logic OSC_CLK,
  input  wire logic BIT_ERR,
  input  wire logic PD_UP_IN,
  input  wire logic PD_DOWN_IN,
  input  wire logic DATA_IN,
  input  wire logic DATA_VALID,
  input  wire logic SPLIT_RST,
  output logic      FD_UP,
  output logic      FD_DOWN,
  output logic      PD_UP_OUT,
  output logic      PD_DOWN_OUT,
  output logic      OUT_OF_WINDOW,
  output logic      CARRIER_ABSENT_FLAG,
  output logic      DATA_D1,
  output logic      DATA_D2
);
  import cfl_pkg::*;

  // two-stage synchronisers, third stage for edge detection
  logic [2:0] ref_sync_reg;
  logic [2:0] osc_sync_reg;
  logic [2:0] err_sync_reg;
  logic [1:0] pdu_sync_reg;
  logic [1:0] pdd_sync_reg;
  logic       ref_edge;
  logic       osc_edge;
  logic       err_edge;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ref_sync_reg <= '0;
      osc_sync_reg <= '0;
      err_sync_reg <= '0;
      pdu_sync_reg <= '0;
      pdd_sync_reg <= '0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[1:0], REF_CLK};
      osc_sync_reg <= {osc_sync_reg[1:0], OSC_CLK};
      err_sync_reg <= {err_sync_reg[1:0], BIT_ERR};
      pdu_sync_reg <= {pdu_sync_reg[0], PD_UP_IN};
      pdd_sync_reg <= {pdd_sync_reg[0], PD_DOWN_IN};
    end
  end

  assign ref_edge = ref_sync_reg[1] && !ref_sync_reg[2];
  assign osc_edge = osc_sync_reg[1] && !osc_sync_reg[2];
  assign err_edge = err_sync_reg[1] && !err_sync_reg[2];

  // frequency window detector
  logic [DIV_CNT_W-1:0] ndiv_reg;
  logic [DIV_CNT_W-1:0] ndiv_next;
  logic [DIV_CNT_W-1:0] xdiv_reg;
  logic [DIV_CNT_W-1:0] xdiv_next;
  logic [FD_CNT_W-1:0]  fcnt_reg;
  logic [FD_CNT_W-1:0]  fcnt_next;
  logic                 oow_reg;
  logic                 oow_next;
  logic                 fd_up_req;
  logic                 fd_dn_req;
  logic                 fd_end;
  logic                 x_tick;

  always_comb begin
    ndiv_next = ndiv_reg;
    xdiv_next = xdiv_reg;
    fcnt_next = fcnt_reg;
    oow_next  = oow_reg;
    fd_up_req = 1'b0;
    fd_dn_req = 1'b0;
    fd_end    = ref_edge && (ndiv_reg == DIV_CNT_W'(N_DIV - 1));
    x_tick    = osc_edge && (xdiv_reg == DIV_CNT_W'(X_DIV - 1));
    if (ref_edge) begin
      ndiv_next = fd_end ? '0 : ndiv_reg + DIV_CNT_W'(1);
    end
    if (osc_edge) begin
      xdiv_next = x_tick ? '0 : xdiv_reg + DIV_CNT_W'(1);
    end
    if (fd_end) begin
      fd_up_req = fcnt_reg < FD_CNT_W'(WIN_LO);
      fd_dn_req = fcnt_reg > FD_CNT_W'(WIN_HI);
      oow_next  = fd_up_req || fd_dn_req;
      fcnt_next = x_tick ? FD_CNT_W'(1) : '0;
    end else if (x_tick && fcnt_reg != '1) begin
      fcnt_next = fcnt_reg + FD_CNT_W'(1);
    end
    if (SYNC_RST) begin
      ndiv_next = '0;
      xdiv_next = '0;
      fcnt_next = '0;
      oow_next  = 1'b0;
      fd_up_req = 1'b0;
      fd_dn_req = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ndiv_reg <= '0;
      xdiv_reg <= '0;
      fcnt_reg <= '0;
      oow_reg  <= 1'b0;
    end else begin
      ndiv_reg <= ndiv_next;
      xdiv_reg <= xdiv_next;
      fcnt_reg <= fcnt_next;
      oow_reg  <= oow_next;
    end
  end

  cfl_pulse_former #(
    .WIDTH    (FD_PULSE_CYC)
  ) u_pulse (
    .clk      (CLK),
    .rst      (RST),
    .sync_rst (SYNC_RST),
    .up_req   (fd_up_req),
    .dn_req   (fd_dn_req),
    .up_pulse (FD_UP),
    .dn_pulse (FD_DOWN)
  );

  // phase signal gating toward the macro phase inputs
  logic pdu_reg;
  logic pdu_next;
  logic pdd_reg;
  logic pdd_next;

  always_comb begin
    pdu_next = pdu_sync_reg[1] && !oow_next && !SYNC_RST;
    pdd_next = pdd_sync_reg[1] && !oow_next && !SYNC_RST;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pdu_reg <= 1'b0;
      pdd_reg <= 1'b0;
    end else begin
      pdu_reg <= pdu_next;
      pdd_reg <= pdd_next;
    end
  end

  // carrier-absent detection with hysteresis
  logic [DIV_CNT_W-1:0] lint_reg;
  logic [DIV_CNT_W-1:0] lint_next;
  logic [ERR_CNT_W-1:0] ecnt_reg;
  logic [ERR_CNT_W-1:0] ecnt_next;
  logic [ERR_CNT_W-1:0] ecnt_inc;
  logic                 flag_reg;
  logic                 flag_next;
  logic                 l_end;

  always_comb begin
    lint_next = lint_reg;
    flag_next = flag_reg;
    ecnt_inc  = ecnt_reg;
    if (err_edge && ecnt_reg != '1) begin
      ecnt_inc = ecnt_reg + ERR_CNT_W'(1);
    end
    ecnt_next = ecnt_inc;
    l_end     = ref_edge && (lint_reg == DIV_CNT_W'(LOS_INT - 1));
    if (ref_edge) begin
      lint_next = l_end ? '0 : lint_reg + DIV_CNT_W'(1);
    end
    if (ecnt_inc >= ERR_CNT_W'(SET_THR)) begin
      flag_next = 1'b1;
    end else if (l_end && ecnt_inc < ERR_CNT_W'(CLR_THR)) begin
      flag_next = 1'b0;
    end
    if (l_end) begin
      ecnt_next = '0;
    end
    if (SYNC_RST) begin
      lint_next = '0;
      ecnt_next = '0;
      flag_next = 1'b0;
    end
  end

  // every stage of the flag path takes the rising edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lint_reg <= '0;
      ecnt_reg <= '0;
      flag_reg <= 1'b0;
    end else begin
      lint_reg <= lint_next;
      ecnt_reg <= ecnt_next;
      flag_reg <= flag_next;
    end
  end

  // 1:2 data split, toggle held in a defined state by SPLIT_RST
  logic tog_reg;
  logic tog_next;
  logic d1_reg;
  logic d1_next;
  logic d2_reg;
  logic d2_next;

  always_comb begin
    tog_next = tog_reg;
    d1_next  = d1_reg;
    d2_next  = d2_reg;
    if (SPLIT_RST || SYNC_RST) begin
      tog_next = 1'b0;
    end else if (DATA_VALID) begin
      tog_next = !tog_reg;
      if (tog_reg) begin
        d2_next = DATA_IN;
      end else begin
        d1_next = DATA_IN;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tog_reg <= 1'b0;
      d1_reg  <= 1'b0;
      d2_reg  <= 1'b0;
    end else begin
      tog_reg <= tog_next;
      d1_reg  <= d1_next;
      d2_reg  <= d2_next;
    end
  end

  assign PD_UP_OUT           = pdu_reg;
  assign PD_DOWN_OUT         = pdd_reg;
  assign OUT_OF_WINDOW       = oow_reg;
  assign CARRIER_ABSENT_FLAG = flag_reg;
  assign DATA_D1             = d1_reg;
  assign DATA_D2             = d2_reg;
endmodule

// file: cfl_recovery_support_properties.sv
// port assertions for the recovery support block
// assumes one CLK domain and asynchronous active-high RST
`timescale 1ns/1ps
module cfl_rs_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SYNC_RST,
  input wire logic DATA_IN,
  input wire logic DATA_VALID,
  input wire logic SPLIT_RST,
  input wire logic FD_UP,
  input wire logic FD_DOWN,
  input wire logic PD_UP_OUT,
  input wire logic PD_DOWN_OUT,
  input wire logic OUT_OF_WINDOW,
  input wire logic CARRIER_ABSENT_FLAG,
  input wire logic DATA_D1,
  input wire logic DATA_D2
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_hold8(s);
    s[*8] ##1 !s;
  endsequence
  a_fd_exclusive: assert property (!(FD_UP && FD_DOWN))
    else $error("up and down pulses overlap");
  a_gate_up: assert property (OUT_OF_WINDOW |-> !PD_UP_OUT)
    else $error("phase up passed while out of window");
  a_gate_down: assert property (OUT_OF_WINDOW |-> !PD_DOWN_OUT)
    else $error("phase down passed while out of window");
  a_up_width: assert property (disable iff (RST || SYNC_RST)
    $rose(FD_UP) |-> s_hold8(FD_UP)) else $error("up pulse width wrong");
  a_down_width: assert property (disable iff (RST || SYNC_RST)
    $rose(FD_DOWN) |-> s_hold8(FD_DOWN)) else $error("down width wrong");
  a_up_cause: assert property ($rose(FD_UP) |-> OUT_OF_WINDOW)
    else $error("up pulse without window miss");
  a_split_refuse: assert property (SPLIT_RST && !SYNC_RST
    |=> $stable(DATA_D1) && $stable(DATA_D2)) else $error("split captured");
  a_split_first: assert property ($past(SPLIT_RST) && !SPLIT_RST
    && DATA_VALID && !SYNC_RST |=> DATA_D1 == $past(DATA_IN))
    else $error("first bit not in d1");
  a_sync_clear: assert property (SYNC_RST |=> !FD_UP && !FD_DOWN
    && !OUT_OF_WINDOW && !CARRIER_ABSENT_FLAG) else $error("not cleared");
endmodule
bind cfl_recovery_support cfl_rs_chk u_chk (.CLK(CLK), .RST(RST),
  .SYNC_RST(SYNC_RST), .DATA_IN(DATA_IN), .DATA_VALID(DATA_VALID),
  .SPLIT_RST(SPLIT_RST), .FD_UP(FD_UP), .FD_DOWN(FD_DOWN),
  .PD_UP_OUT(PD_UP_OUT), .PD_DOWN_OUT(PD_DOWN_OUT),
  .OUT_OF_WINDOW(OUT_OF_WINDOW), .CARRIER_ABSENT_FLAG(CARRIER_ABSENT_FLAG),
  .DATA_D1(DATA_D1), .DATA_D2(DATA_D2));

// file: testbench.sv
// self-checking bench for the recovery support block
// assumes cfl_macro_model drives the macro-side inputs
`timescale 1ns/1ps
module testbench;
  import cfl_pkg::*;
  logic clk, rst, sync_rst, pd_up, pd_dn, d_in, d_vld, split_rst;
  logic fd_up, fd_dn, pu_o, pd_o, oow, flag, d1, d2;
  logic ref_clk, osc_clk, bit_err;
  logic [11:0] osc_per;
  int failures, n_checks;
  cfl_macro_model mac (.osc_per(osc_per), .ref_clk(ref_clk),
    .osc_clk(osc_clk), .bit_err(bit_err));
  cfl_recovery_support #(.N_DIV(4), .X_DIV(2), .WIN_LO(2), .WIN_HI(4),
    .LOS_INT(8), .SET_THR(8), .CLR_THR(4)) dut (.CLK(clk), .RST(rst),
    .SYNC_RST(sync_rst), .REF_CLK(ref_clk), .OSC_CLK(osc_clk),
    .BIT_ERR(bit_err), .PD_UP_IN(pd_up), .PD_DOWN_IN(pd_dn),
    .DATA_IN(d_in), .DATA_VALID(d_vld), .SPLIT_RST(split_rst),
    .FD_UP(fd_up), .FD_DOWN(fd_dn), .PD_UP_OUT(pu_o), .PD_DOWN_OUT(pd_o),
    .OUT_OF_WINDOW(oow), .CARRIER_ABSENT_FLAG(flag),
    .DATA_D1(d1), .DATA_D2(d2));
  task automatic wrap_up;
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // {up, down} for a 160-clock interval and x of 2
  function automatic logic [1:0] fd_exp(input int per);
    int c;
    c = (1600 / (per + 2)) / 2;
    return {c < 2, c > 4};
  endfunction
  task automatic fd_case(input int per);
    logic [1:0] e;
    logic       u, v, pu, pv;
    int         nu, nd;
    e = fd_exp(per);
    u = 1'($urandom);
    v = 1'($urandom);
    osc_per <= 12'(per);
    pd_up <= u;
    pd_dn <= v;
    nu = 0;
    nd = 0;
    repeat (360) @(posedge clk);
    @(negedge clk);
    pu = fd_up;
    pv = fd_dn;
    repeat (320) begin
      @(negedge clk);
      if (fd_up && !pu) nu++;
      if (fd_dn && !pv) nd++;
      pu = fd_up;
      pv = fd_dn;
    end
    chk(2'(nu), e[1] ? 2'h2 : 2'h0);
    chk(2'(nd), e[0] ? 2'h2 : 2'h0);
    chk({1'b0, oow}, {1'b0, |e});
    chk({pu_o, pd_o}, (|e) ? 2'h0 : {u, v});
    @(posedge clk);
  endtask
  task automatic split_run(input int n);
    logic b, pb;
    split_rst <= 1'b1;
    d_vld <= 1'b1;
    @(posedge clk);
    split_rst <= 1'b0;
    pb = 1'b0;
    for (int i = 0; i <= n; i++) begin
      b = 1'($urandom);
      d_in <= b;
      d_vld <= (i < n);
      @(negedge clk);
      if (i > 0) chk({1'b0, i[0] ? d1 : d2}, {1'b0, pb});
      pb = b;
      @(posedge clk);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    wrap_up;
  end
  initial begin
    int k;
    failures = 0;
    n_checks = 0;
    void'($urandom(32'h392F));
    rst = 1'b1;
    sync_rst = 1'b0;
    split_rst = 1'b0;
    d_vld = 1'b0;
    {pd_up, pd_dn, d_in} = 3'($urandom);
    osc_per = 12'hFA;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    fd_case(2000);
    fd_case(250);
    fd_case(100);
    sync_rst <= 1'b1;
    @(posedge clk);
    sync_rst <= 1'b0;
    @(negedge clk);
    chk({fd_dn, oow}, 2'h0);
    @(posedge clk);
    repeat (4) begin
      k = $urandom % 3;
      fd_case(k == 0 ? 1700 + $urandom % 800 :
              k == 1 ? 240 + $urandom % 21 : 80 + $urandom % 41);
    end
    split_run(40);
    mac.err_pulses(16, 30);
    repeat (5) @(posedge clk);
    chk({1'b0, flag}, 2'h1);
    // five errors per interval sit inside the hysteresis band
    mac.err_pulses(10, 610);
    chk({1'b0, flag}, 2'h1);
    repeat (700) @(posedge clk);
    chk({1'b0, flag}, 2'h0);
    mac.err_pulses(7, 370);
    chk({1'b0, flag}, 2'h0);
    wrap_up;
  end
endmodule
